//--- hw/pbseq_pkg.sv
// Package for the push button power sequencer: timing constants, states and carriers.
// Assumes a 40 MHz reference clock; the tick is derived from CLK_HZ, the kill pulse width from CLK_PERIOD_NS.
package pbseq_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned DEBOUNCE_MS     = 32;
   localparam int unsigned BLANK_MS        = 512;
   localparam int unsigned OFF_DELAY_MS    = 1024;
   localparam int unsigned LOCKOUT_MS      = 256;
   localparam int unsigned KILL_PW_NS      = 30_000;
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned KILL_PW_CYC     = (KILL_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TICK_W          = 16;
   localparam int unsigned TMR_W           = 12;
   localparam int unsigned KF_W            = 11;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE    = 8'h01,
      ST_ON_DB   = 8'h02,
      ST_BLANK   = 8'h04,
      ST_REL_ON  = 8'h08,
      ST_RUN     = 8'h10,
      ST_OFF_DB  = 8'h20,
      ST_PWR_DN  = 8'h40,
      ST_LOCKOUT = 8'h80
   } pbseq_state_t;

   // Filtered inputs as seen by the sequencer.
   typedef struct packed {
      logic button_low;
      logic kill_low;
   } pbseq_in_t;

   // Sequencer outputs: enable is the logical level before pin polarity, int_n is the pin level.
   typedef struct packed {
      logic enable;
      logic int_n;
   } pbseq_out_t;

endpackage : pbseq_pkg

//--- hw/pbseq_sync.sv
// Three stage synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is a plain level from outside the ref_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module pbseq_sync
   import pbseq_pkg::*;
#(
   parameter logic RST_VAL = 1'b1
)(
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // A change counts only once the second and third stages agree.
   wire agree = (s2_r == s3_r);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_r    <= RST_VAL;
         s2_r    <= RST_VAL;
         s3_r    <= RST_VAL;
         level_r <= RST_VAL;
      end else begin
         s1_r    <= pin_i;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         if (agree) begin
            level_r <= s3_r;
         end
      end
   end

   assign level_o = level_r;

endmodule : pbseq_sync
`default_nettype wire

//--- hw/pbseq_top.sv
// Push button on/off power sequencer with processor power-down handshake.
// Assumes button and kill pins are asynchronous; one 40 MHz clock drives all logic.
`timescale 1ns/1ps
`default_nettype none
module pbseq_top
   import pbseq_pkg::*;
#(
   parameter logic        EN_ACTIVE_HIGH  = 1'b1,
   parameter logic [11:0] on_time_extend  = 12'h000,
   parameter logic [11:0] off_time_extend = 12'h000,
   parameter logic [11:0] DEBOUNCE_TICKS  = 12'(DEBOUNCE_MS),
   parameter logic [11:0] BLANK_TICKS     = 12'(BLANK_MS),
   parameter logic [11:0] OFF_DLY_TICKS   = 12'(OFF_DELAY_MS),
   parameter logic [11:0] LOCKOUT_TICKS   = 12'(LOCKOUT_MS),
   parameter logic [15:0] TICK_CYCLES     = 16'(TICK_CYC)
)(
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic button_in_n_i,
   input  wire logic kill_n_i,
   output logic      enable_o,
   output logic      int_n_o,
   output logic      int_n_oe_o
);

   // ---------------------------------------------------------------
   // Input conditioning
   // ---------------------------------------------------------------
   logic       button_lvl;
   logic       kill_lvl;
   pbseq_in_t  in_s;

   pbseq_sync #(.RST_VAL(1'b1)) u_btn_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .pin_i     (button_in_n_i),
      .level_o   (button_lvl)
   );

   pbseq_sync #(.RST_VAL(1'b1)) u_kill_sync (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .pin_i     (kill_n_i),
      .level_o   (kill_lvl)
   );

   // Kill low must persist for the minimum pulse width before it counts.
   logic [KF_W-1:0] kill_cnt_r;
   logic            kill_low_r;
   wire             kill_full = (kill_cnt_r == KF_W'(KILL_PW_CYC - 1));

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         kill_cnt_r <= '0;
         kill_low_r <= 1'b0;
      end else if (kill_lvl) begin
         kill_cnt_r <= '0;
         kill_low_r <= 1'b0;
      end else if (kill_full) begin
         kill_low_r <= 1'b1;
      end else begin
         kill_cnt_r <= kill_cnt_r + KF_W'(1);
      end
   end

   assign in_s.button_low = ~button_lvl;
   assign in_s.kill_low   = kill_low_r;

   // ---------------------------------------------------------------
   // Tick generator
   // ---------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt_r;
   wire               tick = (tick_cnt_r == TICK_CYCLES - 16'h0001);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   pbseq_state_t      state_r;
   pbseq_state_t      state_nxt;
   logic [TMR_W-1:0]  tmr_r;
   logic [TMR_W-1:0]  tmr_nxt;
   pbseq_out_t        out_r;
   pbseq_out_t        out_nxt;

   localparam logic [TMR_W-1:0] ON_TICKS  = TMR_W'(DEBOUNCE_TICKS + on_time_extend);
   localparam logic [TMR_W-1:0] OFF_TICKS = TMR_W'(DEBOUNCE_TICKS + off_time_extend);

   wire tmr_done = (tmr_r == '0);
   wire tmr_dec  = tick & ~tmr_done;

   always_comb begin
      state_nxt = state_r;
      tmr_nxt   = tmr_dec ? tmr_r - TMR_W'(1) : tmr_r;
      out_nxt   = out_r;
      case (state_r)
         ST_IDLE: begin
            out_nxt = '{enable: 1'b0, int_n: 1'b1};
            if (in_s.button_low) begin
               state_nxt = ST_ON_DB;
               tmr_nxt   = ON_TICKS;
            end
         end
         ST_ON_DB: begin
            if (!in_s.button_low) begin
               state_nxt = ST_IDLE;
            end else if (tmr_done) begin
               state_nxt      = ST_BLANK;
               out_nxt.enable = 1'b1;
               tmr_nxt        = BLANK_TICKS;
            end
         end
         ST_BLANK: begin
            if (tmr_done) begin
               if (in_s.kill_low) begin
                  state_nxt      = ST_IDLE;
                  out_nxt.enable = 1'b0;
               end else begin
                  state_nxt = ST_REL_ON;
                  tmr_nxt   = DEBOUNCE_TICKS;
               end
            end
         end
         ST_REL_ON: begin
            if (in_s.kill_low) begin
               state_nxt      = ST_LOCKOUT;
               out_nxt.enable = 1'b0;
               tmr_nxt        = LOCKOUT_TICKS;
            end else if (in_s.button_low) begin
               tmr_nxt = DEBOUNCE_TICKS;
            end else if (tmr_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (in_s.kill_low) begin
               state_nxt      = ST_LOCKOUT;
               out_nxt.enable = 1'b0;
               tmr_nxt        = LOCKOUT_TICKS;
            end else if (in_s.button_low) begin
               state_nxt = ST_OFF_DB;
               tmr_nxt   = OFF_TICKS;
            end
         end
         ST_OFF_DB: begin
            if (in_s.kill_low) begin
               state_nxt      = ST_LOCKOUT;
               out_nxt.enable = 1'b0;
               tmr_nxt        = LOCKOUT_TICKS;
            end else if (!in_s.button_low) begin
               state_nxt = ST_RUN;
            end else if (tmr_done) begin
               state_nxt     = ST_PWR_DN;
               out_nxt.int_n = 1'b0;
               tmr_nxt       = OFF_DLY_TICKS;
            end
         end
         ST_PWR_DN: begin
            if (in_s.kill_low) begin
               state_nxt = ST_LOCKOUT;
               out_nxt   = '{enable: 1'b0, int_n: 1'b1};
               tmr_nxt   = LOCKOUT_TICKS;
            end else if (tmr_done) begin
               state_nxt = ST_LOCKOUT;
               out_nxt   = '{enable: 1'b0, int_n: 1'b1};
               tmr_nxt   = LOCKOUT_TICKS;
            end
         end
         ST_LOCKOUT: begin
            // Button ignored during lockout; then its release is debounced.
            if (!tmr_done) begin
               tmr_nxt = tmr_dec ? tmr_r - TMR_W'(1) : tmr_r;
            end else if (in_s.button_low) begin
               tmr_nxt = DEBOUNCE_TICKS;
            end else if (tmr_r == '0) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            out_nxt   = '{enable: 1'b0, int_n: 1'b1};
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         tmr_r   <= '0;
         out_r   <= '{enable: 1'b0, int_n: 1'b1};
      end else begin
         state_r <= state_nxt;
         tmr_r   <= tmr_nxt;
         out_r   <= out_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Output pins
   // ---------------------------------------------------------------
   logic en_pin_r;
   logic int_oe_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         en_pin_r <= ~EN_ACTIVE_HIGH;
         int_oe_r <= 1'b0;
      end else begin
         en_pin_r <= out_nxt.enable ~^ ~EN_ACTIVE_HIGH ? 1'b0 : 1'b1;
         int_oe_r <= ~out_nxt.int_n;
      end
   end

   assign enable_o   = en_pin_r;
   assign int_n_o    = out_r.int_n;
   assign int_n_oe_o = int_oe_r;

endmodule : pbseq_top
`default_nettype wire

//--- bench/pbseq_checker.sv
// Pin checker for pbseq_top.
// Assumes it is bound to pbseq_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pbseq_checker
   import pbseq_pkg::*;
#(
   parameter logic        EN_ACTIVE_HIGH  = 1'b1,
   parameter logic [11:0] on_time_extend  = 12'h000,
   parameter logic [11:0] off_time_extend = 12'h000,
   parameter logic [11:0] DEBOUNCE_TICKS  = 12'h020,
   parameter logic [11:0] BLANK_TICKS     = 12'h200,
   parameter logic [11:0] OFF_DLY_TICKS   = 12'h400,
   parameter logic [15:0] TICK_CYCLES     = 16'h9c40
)(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic button_in_n_i,
   input wire logic kill_n_i,
   input wire logic enable_o,
   input wire logic int_n_o,
   input wire logic int_n_oe_o
);
   localparam int TK  = int'(TICK_CYCLES);
   localparam int DB  = int'(DEBOUNCE_TICKS);
   localparam int BLK = int'(BLANK_TICKS) * TK;
   localparam int KPW = int'(KILL_PW_CYC);
   logic en_on;
   int   btn_r;
   int   kil_r;
   int   age_r;
   int   int_r;
   assign en_on = (enable_o == EN_ACTIVE_HIGH);
   // Run lengths of button low, kill low, enable on and interrupt low.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         btn_r <= 0;
         kil_r <= 0;
         age_r <= 0;
         int_r <= 0;
      end else begin
         btn_r <= button_in_n_i ? 0 : btn_r + 1;
         kil_r <= kill_n_i ? 0 : kil_r + 1;
         age_r <= en_on ? age_r + 1 : 0;
         int_r <= int_n_o ? 0 : int_r + 1;
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   a_reset_off: assert property ($rose(resetn_i) |-> !en_on && int_n_o)
      else $error("output active after reset");
   a_on_press: assert property ($rose(en_on) |-> btn_r >= (DB+int'(on_time_extend)-1)*TK)
      else $error("enable without full press");
   a_off_press: assert property ($fell(int_n_o) |-> btn_r >= (DB+int'(off_time_extend)-1)*TK)
      else $error("interrupt without full press");
   a_blank_hold: assert property ($fell(en_on) |-> age_r >= BLK - TK)
      else $error("enable released inside blanking");
   a_abort_end: assert property (en_on && kil_r > age_r |-> age_r <= BLK + TK)
      else $error("no abort at blanking end");
   a_kill_acts: assert property (en_on && age_r > BLK + TK |-> kil_r <= KPW + 16)
      else $error("kill low did not release enable");
   a_off_limit: assert property (!int_n_o |-> int_r <= int'(OFF_DLY_TICKS) * TK + TK)
      else $error("power-down timer overran");
   a_int_with_en: assert property (!int_n_o |-> en_on)
      else $error("interrupt low while enable released");
   a_oe_follows: assert property (int_n_oe_o == !int_n_o)
      else $error("interrupt enable mismatch");
   c_on: cover property ($rose(en_on));
   c_int: cover property ($fell(int_n_o));
   c_ack: cover property ($fell(en_on) && !int_n_o);
endmodule : pbseq_checker
`default_nettype wire

//--- bench/pbseq_host.sv
// Model of the push button and the system processor.
// Assumes the bench sets its controls between clock edges.
`timescale 1ns/1ps
`default_nettype none
module pbseq_host #(
   parameter int BOOT_CYC = 600,
   parameter int ACK_CYC  = 500
)(
   input  wire logic ref_clk_i,
   input  wire logic en_on_i,
   input  wire logic int_n_i,
   input  wire logic press_i,
   input  wire logic boot_ok_i,
   input  wire logic ack_en_i,
   input  wire logic kill_force_i,
   output var logic  button_in_n_o,
   output wire logic kill_n_o
);
   logic up_r  = 1'b0;
   int   cnt_r = 0;
   always @(negedge ref_clk_i) begin
      button_in_n_o <= ~press_i;
      if (!en_on_i) begin
         up_r  <= 1'b0;
         cnt_r <= 0;
      end else if (!up_r && boot_ok_i && int_n_i) begin
         cnt_r <= cnt_r + 1;
         up_r  <= (cnt_r == BOOT_CYC);
      end else if (up_r && !int_n_i && ack_en_i) begin
         cnt_r <= cnt_r + 1;
         up_r  <= (cnt_r != BOOT_CYC + ACK_CYC);
      end
   end
   // An unpowered processor leaves kill low.
   assign kill_n_o = up_r & ~kill_force_i;
endmodule : pbseq_host
`default_nettype wire

//--- bench/testbench.sv
// Bench for pbseq_top driven through the button and processor model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // The tick is shortened and the on and off press times are extended; every other period keeps its documented tick count.
   localparam int TK     = 4;
   localparam int ON_EXT = 160;
   localparam int OF_EXT = 192;
   localparam int ON_T   = int'(pbseq_pkg::DEBOUNCE_MS) + ON_EXT;
   localparam int OF_T   = int'(pbseq_pkg::DEBOUNCE_MS) + OF_EXT;
   localparam int BL     = int'(pbseq_pkg::BLANK_MS);
   localparam int OD     = int'(pbseq_pkg::OFF_DELAY_MS);
   logic ref_clk_i;
   logic resetn_i;
   logic press;
   logic boot_ok;
   logic ack_en;
   logic kill_force;
   wire logic button_n, kill_n, enable_o, int_n_o, int_n_oe_o;
   int   miscompares = 0;
   int   cmp_count   = 0;
   int   n;
   pbseq_top #(.on_time_extend(12'(ON_EXT)), .off_time_extend(12'(OF_EXT)),
      .TICK_CYCLES(16'(TK))) pbseq_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .button_in_n_i(button_n), .kill_n_i(kill_n), .enable_o(enable_o), .int_n_o(int_n_o),
      .int_n_oe_o(int_n_oe_o));
   pbseq_host pbseq_host_i (.ref_clk_i(ref_clk_i), .en_on_i(enable_o), .int_n_i(int_n_o),
      .press_i(press), .boot_ok_i(boot_ok), .ack_en_i(ack_en), .kill_force_i(kill_force),
      .button_in_n_o(button_n), .kill_n_o(kill_n));
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit
   task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
      cmp_count++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : cmp_rng
   task automatic hold(input logic p, input int c);
      press = p;
      repeat (c) @(negedge ref_clk_i);
   endtask : hold
   task automatic wait_for(input bit on_int, input logic lvl, input int lim);
      for (n = 0; n < lim; n++) begin
         if ((on_int ? int_n_o : enable_o) === lvl)
            return;
         @(negedge ref_clk_i);
      end
      miscompares++;
      $display("Error wait expected %b seen timeout", lvl);
      wrap_up();
   endtask : wait_for
   task automatic power_on();
      boot_ok = 1'b1;
      press   = 1'b1;
      wait_for(0, 1'b1, 3000);
      cmp_rng("on_time", (ON_T - 1) * TK, ON_T * TK + 40, n);
      hold(1, 3800);
      cmp_bit("int_n", 1'b1, int_n_o);
      hold(0, 1500);
      cmp_bit("enable", 1'b1, enable_o);
   endtask : power_on
   task automatic s_abort();
      hold(1, 700);
      hold(0, 100);
      hold(1, 700);
      hold(0, 200);
      cmp_bit("enable", 1'b0, enable_o);
      boot_ok = 1'b0;
      press   = 1'b1;
      wait_for(0, 1'b1, 3000);
      press = 1'b0;
      wait_for(0, 1'b0, 3000);
      cmp_rng("blank_time", (BL - 1) * TK, BL * TK + 40, n);
      hold(0, 300);
   endtask : s_abort
   task automatic s_off(input logic ack);
      power_on();
      ack_en = ack;
      press  = 1'b1;
      wait_for(1, 1'b0, 3000);
      cmp_rng("off_time", (OF_T - 1) * TK, OF_T * TK + 40, n);
      cmp_bit("int_oe", 1'b1, int_n_oe_o);
      press = 1'b0;
      wait_for(0, 1'b0, 5000);
      if (ack)
         cmp_rng("ack_release", 1600, 1800, n);
      else
         cmp_rng("off_timeout", (OD - 1) * TK, OD * TK + 40, n);
      cmp_bit("int_n", 1'b1, int_n_o);
      ack_en = 1'b1;
      hold(0, 300);
      hold(1, 1400);
      cmp_bit("enable", 1'b0, enable_o);
      hold(0, 1500);
   endtask : s_off
   task automatic s_kill();
      power_on();
      kill_force = 1'b1;
      hold(0, 600);
      kill_force = 1'b0;
      hold(0, 200);
      cmp_bit("enable", 1'b1, enable_o);
      kill_force = 1'b1;
      wait_for(0, 1'b0, 1500);
      cmp_rng("kill_delay", 1190, 1260, n);
      kill_force = 1'b0;
      hold(0, 3000);
   endtask : s_kill
   initial begin
      resetn_i   = 1'b0;
      press      = 1'b0;
      boot_ok    = 1'b1;
      ack_en     = 1'b1;
      kill_force = 1'b0;
      repeat (12) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      @(negedge ref_clk_i);
      cmp_bit("enable", 1'b0, enable_o);
      cmp_bit("int_n", 1'b1, int_n_o);
      s_abort();
      s_off(1'b1);
      s_kill();
      s_off(1'b0);
      wrap_up();
   end
endmodule : testbench
bind pbseq_top pbseq_checker #(.EN_ACTIVE_HIGH(EN_ACTIVE_HIGH),
   .on_time_extend(on_time_extend), .off_time_extend(off_time_extend),
   .DEBOUNCE_TICKS(DEBOUNCE_TICKS), .BLANK_TICKS(BLANK_TICKS), .OFF_DLY_TICKS(OFF_DLY_TICKS),
   .TICK_CYCLES(TICK_CYCLES)) pbseq_checker_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
   .button_in_n_i(button_in_n_i), .kill_n_i(kill_n_i), .enable_o(enable_o),
   .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));
`default_nettype wire
